// File: bit_io_unit.sv
// Purpose: processor side of the bit-addressed serial I/O, external codes and load trap.
// Assumes: commands arrive at instruction boundaries; one clock phase per cycle.
// Notes: memory cycles here serve only the load trap; hold is taken between cycles.
module bit_io_unit (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // command from the instruction sequencer
   input wire logic cmd_valid,
   input wire bit_io_pkg::op_t cmd_op,
   input wire logic [15:0] cmd_instr,
   input wire logic [15:0] cmd_base,
   input wire logic [4:0] cmd_count,
   input wire logic [2:0] cmd_ext_code,
   input wire logic [15:0] cmd_data,
   input wire logic cmd_byte_odd,
   output logic cmd_ready,
   // completion
   output logic done,
   output logic [15:0] result,
   output logic result_is_byte,
   output logic [15:0] status_word,
   // processor context
   input wire logic [15:0] program_counter,
   input wire logic [15:0] workspace_ptr,
   input wire logic [15:0] cur_status,
   input wire logic intr_pending,
   input wire logic load_request_n,
   output logic trap_done,
   output logic [15:0] trap_pc,
   output logic [15:0] trap_wp,
   // address and memory control
   output logic [14:0] addr_bus,
   output logic addr_oe,
   output logic memory_enable_n,
   output logic write_enable_n,
   output logic data_bus_in_en,
   output logic mem_ctrl_oe,
   input wire logic ready,
   // data bus
   input wire logic [15:0] data_in,
   output logic [15:0] data_out,
   output logic data_oe,
   // hold
   input wire logic hold_request_n,
   output logic hold_acknowledge,
   // serial bit i/o
   output logic io_strobe,
   output logic serial_out_line,
   input wire logic serial_in_line
);
   bit_io_pkg::state_t state_q;
   bit_io_pkg::state_t state_d;
   bit_io_pkg::op_t op_q;
   logic [15:0] instr_q;
   logic [15:0] base_q;
   logic [4:0] count_q;
   logic [4:0] idx_q;
   logic [15:0] shift_q;
   logic [15:0] store_q;
   logic [2:0] ext_q;
   logic byte_q;
   logic io_active_q;
   logic done_q;
   logic [15:0] status_q;
   logic load_pend_q;
   logic [2:0] tstep_q;
   logic [15:0] new_wp_q;
   logic [15:0] new_pc_q;
   logic [15:0] old_pc_q;
   logic [15:0] old_wp_q;
   logic [15:0] old_st_q;
   logic [11:0] bit_addr;
   logic [15:0] ld_field;
   logic cmd_is_byte;
   logic accept;
   logic trap_start;
   logic single_op;
   logic multi_op;
   logic strobe_op;
   logic sampling_op;
   logic is_ext;
   logic more_bits;
   logic idle_repeat;
   logic finish;
   logic mem_write;
   logic [15:0] mem_addr;
   logic io_phase;

   bit_addr_calc #(
      .AW(bit_io_pkg::BIT_ADDR_W)
   ) u_addr (
      .base_word(base_q),
      .disp(single_op ? instr_q[7:0] : 8'h00),
      .offset(idx_q),
      .bit_addr(bit_addr)
   );

   field_justify u_field (
      .word(cmd_data),
      .byte_odd(cmd_byte_odd),
      .count(cmd_count),
      .field(ld_field),
      .is_byte(cmd_is_byte)
   );

   // op decode
   assign single_op = (op_q == bit_io_pkg::OP_SET_ONE) || (op_q == bit_io_pkg::OP_SET_ZERO)
                      || (op_q == bit_io_pkg::OP_TEST);
   assign multi_op = (op_q == bit_io_pkg::OP_LOAD_MULTI) || (op_q == bit_io_pkg::OP_STORE_MULTI);
   assign is_ext = (op_q == bit_io_pkg::OP_EXTERNAL);
   assign sampling_op = (op_q == bit_io_pkg::OP_TEST) || (op_q == bit_io_pkg::OP_STORE_MULTI);
   // inputs are read without a strobe; outputs and codes get one
   assign strobe_op = !sampling_op;
   assign more_bits = multi_op && (idx_q != 5'(count_q - 5'h01));
   assign idle_repeat = is_ext && (ext_q == bit_io_pkg::IDLE_CODE)
                        && !intr_pending && !load_pend_q;
   assign finish = (state_q == bit_io_pkg::S_STROBE) && !more_bits && !idle_repeat;
   assign io_phase = (state_q == bit_io_pkg::S_SETUP) || (state_q == bit_io_pkg::S_STROBE)
                     || (state_q == bit_io_pkg::S_REPRESENT);

   // handshake
   assign cmd_ready = (state_q == bit_io_pkg::S_READY) && !load_pend_q && hold_request_n;
   assign accept = cmd_valid && cmd_ready;
   // trap waits for the current op to finish
   assign trap_start = (state_q == bit_io_pkg::S_READY) && load_pend_q && hold_request_n;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         bit_io_pkg::S_READY: begin
            if (!hold_request_n) begin
               state_d = bit_io_pkg::S_HOLD;
            end else if (load_pend_q) begin
               state_d = bit_io_pkg::S_MEM;
            end else if (cmd_valid) begin
               state_d = bit_io_pkg::S_SETUP;
            end
         end
         bit_io_pkg::S_SETUP: begin
            state_d = !hold_request_n ? bit_io_pkg::S_HOLD : bit_io_pkg::S_STROBE;
         end
         bit_io_pkg::S_STROBE: begin
            state_d = (more_bits || idle_repeat) ? bit_io_pkg::S_SETUP
                                                 : bit_io_pkg::S_READY;
         end
         bit_io_pkg::S_HOLD: begin
            if (hold_request_n) begin
               // extra cycle re-presents the bit address before the strobe
               state_d = io_active_q ? bit_io_pkg::S_REPRESENT : bit_io_pkg::S_READY;
            end
         end
         bit_io_pkg::S_REPRESENT: begin
            state_d = bit_io_pkg::S_SETUP;
         end
         bit_io_pkg::S_MEM: begin
            if (ready && (tstep_q == bit_io_pkg::TRAP_LAST_STEP)) begin
               state_d = bit_io_pkg::S_TRAP_END;
            end
         end
         bit_io_pkg::S_TRAP_END: begin
            state_d = bit_io_pkg::S_READY;
         end
         default: begin
            state_d = bit_io_pkg::S_READY;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_q <= bit_io_pkg::S_READY;
      end else begin
         state_q <= state_d;
      end
   end

   // load request is sticky until the trap starts; a new request wins
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         load_pend_q <= 1'b0;
      end else begin
         load_pend_q <= !load_request_n || (load_pend_q && !trap_start);
      end
   end

   // operation capture and bit sequencing
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         op_q <= bit_io_pkg::OP_SET_ONE;
         instr_q <= 16'h0000;
         base_q <= 16'h0000;
         count_q <= 5'h01;
         ext_q <= 3'h0;
         byte_q <= 1'b0;
         idx_q <= 5'h00;
         shift_q <= 16'h0000;
         store_q <= 16'h0000;
      end else if (accept) begin
         op_q <= cmd_op;
         instr_q <= cmd_instr;
         base_q <= cmd_base;
         count_q <= bit_io_pkg::eff_count(cmd_count);
         ext_q <= cmd_ext_code;
         byte_q <= cmd_is_byte;
         idx_q <= 5'h00;
         shift_q <= ld_field;
         store_q <= 16'h0000;
      end else if (state_q == bit_io_pkg::S_STROBE) begin
         if (op_q == bit_io_pkg::OP_STORE_MULTI) begin
            store_q[idx_q[3:0]] <= serial_in_line;
         end
         if (more_bits) begin
            idx_q <= 5'(idx_q + 5'h01);
            shift_q <= shift_q >> 1;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         io_active_q <= 1'b0;
      end else if (accept) begin
         io_active_q <= 1'b1;
      end else if (finish) begin
         io_active_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         done_q <= 1'b0;
      end else begin
         done_q <= finish;
      end
   end

   // status: equal bit from test, mask cleared by the load trap
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         status_q <= 16'h0000;
      end else if ((state_q == bit_io_pkg::S_STROBE) && (op_q == bit_io_pkg::OP_TEST)) begin
         status_q <= cur_status;
         status_q[bit_io_pkg::ST_EQ_BIT] <= serial_in_line;
      end else if (state_q == bit_io_pkg::S_TRAP_END) begin
         status_q <= {old_st_q[15:4], bit_io_pkg::LOAD_MASK};
      end
   end

   // load trap: two vector reads then three context writes
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tstep_q <= 3'h0;
         new_wp_q <= 16'h0000;
         new_pc_q <= 16'h0000;
         old_pc_q <= 16'h0000;
         old_wp_q <= 16'h0000;
         old_st_q <= 16'h0000;
      end else if (trap_start) begin
         tstep_q <= 3'h0;
         old_pc_q <= program_counter;
         old_wp_q <= workspace_ptr;
         old_st_q <= cur_status;
      end else if ((state_q == bit_io_pkg::S_MEM) && ready) begin
         if (tstep_q == 3'h0) begin
            new_wp_q <= data_in;
         end
         if (tstep_q == 3'h1) begin
            new_pc_q <= data_in;
         end
         if (tstep_q != bit_io_pkg::TRAP_LAST_STEP) begin
            tstep_q <= 3'(tstep_q + 3'h1);
         end
      end
   end

   assign mem_write = (tstep_q >= bit_io_pkg::TRAP_FIRST_WRITE);

   always_comb begin
      mem_addr = bit_io_pkg::LOAD_VEC_ADDR;
      data_out = old_wp_q;
      unique case (tstep_q)
         3'h0: mem_addr = bit_io_pkg::LOAD_VEC_ADDR;
         3'h1: mem_addr = bit_io_pkg::LOAD_PC_ADDR;
         3'h2: mem_addr = new_wp_q + bit_io_pkg::WS_WP_OFF;
         3'h3: begin
            mem_addr = new_wp_q + bit_io_pkg::WS_PC_OFF;
            data_out = old_pc_q;
         end
         3'h4: begin
            mem_addr = new_wp_q + bit_io_pkg::WS_ST_OFF;
            data_out = old_st_q;
         end
         default: mem_addr = bit_io_pkg::LOAD_VEC_ADDR;
      endcase
   end

   // address bus: memory word address with enable, else bit address or code
   always_comb begin
      addr_bus = 15'h0000;
      if (state_q == bit_io_pkg::S_MEM) begin
         addr_bus = mem_addr[15:1];
      end else if (io_phase) begin
         addr_bus = is_ext ? {ext_q, 12'h000} : {3'h0, bit_addr};
      end
   end

   // buses float in hold; no memory enable outside trap cycles
   assign hold_acknowledge = (state_q == bit_io_pkg::S_HOLD);
   assign addr_oe = !hold_acknowledge;
   assign mem_ctrl_oe = !hold_acknowledge;
   assign memory_enable_n = (state_q != bit_io_pkg::S_MEM);
   assign write_enable_n = !((state_q == bit_io_pkg::S_MEM) && mem_write);
   assign data_bus_in_en = (state_q == bit_io_pkg::S_MEM) && !mem_write;
   assign data_oe = (state_q == bit_io_pkg::S_MEM) && mem_write;

   // one strobe per output bit or code, repeated while the idle code waits; none for input ops
   assign io_strobe = (state_q == bit_io_pkg::S_STROBE) && strobe_op;

   always_comb begin
      serial_out_line = 1'b0;
      if (io_phase) begin
         unique case (op_q)
            bit_io_pkg::OP_SET_ONE,
            bit_io_pkg::OP_SET_ZERO: serial_out_line = instr_q[bit_io_pkg::INSTR_BIT7];
            bit_io_pkg::OP_LOAD_MULTI: serial_out_line = shift_q[0];
            default: serial_out_line = 1'b0;
         endcase
      end
   end

   assign done = done_q;
   assign result = store_q;
   assign result_is_byte = byte_q;
   assign status_word = status_q;
   assign trap_done = (state_q == bit_io_pkg::S_TRAP_END);
   assign trap_pc = new_pc_q;
   assign trap_wp = new_wp_q;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   property p_set_data;
      io_strobe && single_op |-> serial_out_line == (op_q == bit_io_pkg::OP_SET_ONE);
   endproperty
   a_set_data: assert property (p_set_data) else $error("set op drives wrong level");

   property p_strobe_width;
      io_strobe |=> !io_strobe;
   endproperty
   a_strobe_width: assert property (p_strobe_width) else $error("strobe wider than one cycle");

   property p_stable_around;
      $rose(io_strobe) |-> $stable(addr_bus) && $stable(serial_out_line);
   endproperty
   a_stable_around: assert property (p_stable_around) else $error("strobe without setup");

   property p_no_memory_enable_n_io;
      io_phase |-> memory_enable_n;
   endproperty
   a_no_memory_enable_n_io: assert property (p_no_memory_enable_n_io) else $error("memory enable during bit i/o");

   property p_hold_float;
      hold_acknowledge |-> !addr_oe && !data_oe && !mem_ctrl_oe;
   endproperty
   a_hold_float: assert property (p_hold_float) else $error("bus driven in hold");

   property p_represent;
      $fell(hold_acknowledge) && io_active_q && strobe_op
         |-> !io_strobe ##1 !io_strobe ##1 (io_strobe || hold_acknowledge);
   endproperty
   a_represent: assert property (p_represent) else $error("no extra cycle after hold");

   property p_test_eq;
      (state_q == bit_io_pkg::S_STROBE) && (op_q == bit_io_pkg::OP_TEST)
         |=> status_word[bit_io_pkg::ST_EQ_BIT] == $past(serial_in_line);
   endproperty
   a_test_eq: assert property (p_test_eq) else $error("equal bit not copied");

   property p_vector;
      $rose(!memory_enable_n) |-> addr_bus == bit_io_pkg::LOAD_VEC_ADDR[15:1];
   endproperty
   a_vector: assert property (p_vector) else $error("trap vector address wrong");

   property p_mask;
      trap_done |=> status_word[3:0] == bit_io_pkg::LOAD_MASK && done == 1'b0;
   endproperty
   a_mask: assert property (p_mask) else $error("mask not cleared by trap");

   property p_ext_code;
      io_strobe && is_ext |-> addr_bus[14:12] == ext_q && addr_bus[11:0] == 12'h000;
   endproperty
   a_ext_code: assert property (p_ext_code) else $error("external code not shown");
endmodule : bit_io_unit

// File: bit_io_pkg.sv
// Purpose: shared constants and types for the bit-addressed serial I/O unit.
// Assumes: one clock; address bus bit 14 is the most significant line, bit 0 the least.
// Notes: status bits are numbered with bit 0 as the least significant (bit 15 is the MSB).
package bit_io_pkg;
   typedef enum logic [2:0] {
      OP_SET_ONE = 3'h0,
      OP_SET_ZERO = 3'h1,
      OP_TEST = 3'h2,
      OP_LOAD_MULTI = 3'h3,
      OP_STORE_MULTI = 3'h4,
      OP_EXTERNAL = 3'h5
   } op_t;

   // gray steps on ready-setup-strobe, ready-hold-represent and ready-mem-trap end only
   typedef enum logic [3:0] {
      S_READY = 4'h0,
      S_SETUP = 4'h1,
      S_STROBE = 4'h3,
      S_HOLD = 4'h2,
      S_REPRESENT = 4'h6,
      S_MEM = 4'h4,
      S_TRAP_END = 4'h5
   } state_t;

   localparam logic [2:0] LOAD_RESTART_CODE = 3'h7;
   localparam logic [2:0] CLOCK_OFF_CODE = 3'h6;
   localparam logic [2:0] CLOCK_ON_CODE = 3'h5;
   localparam logic [2:0] EXT_RESET_CODE = 3'h3;
   localparam logic [2:0] IDLE_CODE = 3'h2;

   localparam int BIT_ADDR_W = 12;
   localparam int INSTR_BIT7 = 8;
   localparam logic [4:0] MAX_BITS = 5'h10;
   localparam logic [4:0] BYTE_BITS = 5'h08;
   localparam int ST_EQ_BIT = 13;
   localparam logic [3:0] LOAD_MASK = 4'h0;

   localparam logic [15:0] LOAD_VEC_ADDR = 16'hFFFC;
   localparam logic [15:0] LOAD_PC_ADDR = 16'hFFFE;
   localparam logic [15:0] WS_WP_OFF = 16'h001A;
   localparam logic [15:0] WS_PC_OFF = 16'h001C;
   localparam logic [15:0] WS_ST_OFF = 16'h001E;
   localparam logic [2:0] TRAP_LAST_STEP = 3'h4;
   localparam logic [2:0] TRAP_FIRST_WRITE = 3'h2;

   // a count of zero stands for a full sixteen-bit field
   function automatic logic [4:0] eff_count(input logic [4:0] cnt);
      return (cnt == 5'h00) ? MAX_BITS : cnt;
   endfunction : eff_count
endpackage : bit_io_pkg

// File: bit_addr_calc.sv
// Purpose: bit address from a base word, signed displacement and bit index.
// Assumes: base sits in bits 12..1 of the base word; bit 0 ignored.
// Notes: sum wraps within the twelve-bit bit space.
module bit_addr_calc #(
   parameter int AW = 12
) (
   // base and offsets
   input wire logic [15:0] base_word,
   input wire logic [7:0] disp,
   input wire logic [4:0] offset,
   // result
   output logic [AW-1:0] bit_addr
);
   function automatic logic [AW-1:0] sext(input logic [7:0] d);
      return {{(AW-8){d[7]}}, d};
   endfunction : sext

   // base -128..+127, then next higher address per bit
   assign bit_addr = base_word[AW:1] + sext(disp) + AW'(offset);
endmodule : bit_addr_calc

// File: field_justify.sv
// Purpose: picks the right-justified field that a multi-bit load shifts out.
// Assumes: odd byte is the low half of the word.
// Notes: bits above the field are cleared so nothing stray reaches the line.
module field_justify (
   // operand
   input wire logic [15:0] word,
   input wire logic byte_odd,
   input wire logic [4:0] count,
   // field
   output logic [15:0] field,
   output logic is_byte
);
   logic [4:0] n;
   logic [15:0] sel;

   assign n = bit_io_pkg::eff_count(count);
   assign is_byte = (n <= bit_io_pkg::BYTE_BITS);
   // byte field for eight or fewer bits, whole word above
   assign sel = is_byte ? {8'h00, (byte_odd ? word[7:0] : word[15:8])} : word;

   always_comb begin
      field = sel;
      for (int i = 0; i < 16; i++) begin
         if (5'(i) >= n) begin
            field[i] = 1'b0;
         end
      end
   end
endmodule : field_justify

// File: bit_io_peer.sv
// Purpose: far-side decode logic for the bit-addressed serial I/O unit.
// Assumes: only the low 1024 bit addresses are populated.
// Notes: an unselected input line toggles so a stale value never passes.
module bit_io_peer (
   // clock
   input wire logic mclk,
   // from the unit
   input wire logic [14:0] addr_bus,
   input wire logic addr_oe,
   input wire logic memory_enable_n,
   input wire logic io_strobe,
   input wire logic serial_out_line,
   // to the unit
   output logic serial_in_line
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1023:0] out_bits;
   logic [1023:0] in_bits;
   logic [2:0] last_code;
   logic strobe_q;
   logic bit_sel;
   int nstrobe;

   initial begin
      out_bits = '0;
      in_bits = '0;
      last_code = 3'h0;
      strobe_q = 1'b0;
      nstrobe = 0;
      serial_in_line = 1'b0;
   end

   // bit decode blocked while a code sits on the top lines
   assign bit_sel = addr_oe && memory_enable_n && (addr_bus[14:12] == 3'h0);

   always @(posedge mclk) begin
      strobe_q <= io_strobe;
      if (io_strobe && !strobe_q) begin
         nstrobe <= nstrobe + 1;
         if (bit_sel) begin
            out_bits[addr_bus[9:0]] <= serial_out_line;
         end else begin
            last_code <= addr_bus[14:12];
         end
      end
   end

   always @(negedge mclk) begin
      serial_in_line <= bit_sel ? in_bits[addr_bus[9:0]] : ~serial_in_line;
   end
endmodule : bit_io_peer

// File: bit_io_unit_tb.sv
// Purpose: self-checking bench for the bit-addressed serial I/O unit.
// Assumes: memory always ready; the peer model answers bit reads.
// Notes: inputs change on the falling edge only.
module bit_io_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 0, rst = 1, cmd_valid = 0, cmd_byte_odd = 0, cmd_ready, done, result_is_byte;
   bit_io_pkg::op_t cmd_op = bit_io_pkg::OP_SET_ONE;
   logic [15:0] cmd_instr = 0, cmd_base = 0, cmd_data = 0, result, status_word, trap_pc, trap_wp;
   logic [4:0] cmd_count = 0;
   logic [2:0] cmd_ext_code = 0;
   logic [15:0] program_counter = 16'h1234, workspace_ptr = 16'h0300, cur_status = 16'hC00F;
   logic intr_pending = 0, load_request_n = 1, ready = 1, hold_request_n = 1;
   logic [15:0] data_in = 0, data_out;
   logic trap_done, addr_oe, memory_enable_n, write_enable_n, data_bus_in_en, mem_ctrl_oe;
   logic data_oe, hold_acknowledge, io_strobe, serial_out_line, serial_in_line;
   logic [14:0] addr_bus;
   int failures = 0, num_checks = 0, code_mem = 0;

   bit_io_unit uut (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_instr(cmd_instr), .cmd_base(cmd_base), .cmd_count(cmd_count),
      .cmd_ext_code(cmd_ext_code), .cmd_data(cmd_data), .cmd_byte_odd(cmd_byte_odd),
      .cmd_ready(cmd_ready), .done(done), .result(result), .result_is_byte(result_is_byte),
      .status_word(status_word), .program_counter(program_counter),
      .workspace_ptr(workspace_ptr), .cur_status(cur_status), .intr_pending(intr_pending),
      .load_request_n(load_request_n), .trap_done(trap_done), .trap_pc(trap_pc),
      .trap_wp(trap_wp), .addr_bus(addr_bus), .addr_oe(addr_oe),
      .memory_enable_n(memory_enable_n), .write_enable_n(write_enable_n),
      .data_bus_in_en(data_bus_in_en), .mem_ctrl_oe(mem_ctrl_oe), .ready(ready),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .hold_request_n(hold_request_n), .hold_acknowledge(hold_acknowledge),
      .io_strobe(io_strobe), .serial_out_line(serial_out_line), .serial_in_line(serial_in_line));

   bit_io_peer peer (.mclk(mclk), .addr_bus(addr_bus), .addr_oe(addr_oe),
      .memory_enable_n(memory_enable_n), .io_strobe(io_strobe),
      .serial_out_line(serial_out_line), .serial_in_line(serial_in_line));

   always #5 mclk = ~mclk;

   // vector memory: new workspace from the first word, new pc from the second
   always @(negedge mclk) begin
      data_in <= ({addr_bus, 1'b0} == 16'hFFFC) ? 16'h0400 : 16'h5000;
      if (io_strobe === 1'b1 && addr_bus[14:12] !== 3'h0 && memory_enable_n !== 1'b1) begin
         code_mem <= code_mem + 1;
      end
   end

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic issue(input bit_io_pkg::op_t op, input logic [15:0] instr,
         input logic [11:0] ba, input logic [4:0] cnt, input logic [2:0] code,
         input logic [15:0] data);
      @(negedge mclk);
      cmd_valid = 1;
      cmd_op = op;
      cmd_instr = instr;
      cmd_base = {3'h0, ba, 1'b0};
      cmd_count = cnt;
      cmd_ext_code = code;
      cmd_data = data;
      while (cmd_ready !== 1'b1) @(negedge mclk);
      @(negedge mclk);
      cmd_valid = 0;
   endtask : issue

   task automatic finish(output int n);
      n = 0;
      while (done !== 1'b1 && n < 300) begin
         @(negedge mclk);
         n++;
      end
      check("done seen", 16'h0001, 16'(n < 300));
   endtask : finish

   task automatic single_ops();
      int n;
      issue(bit_io_pkg::OP_SET_ONE, 16'h01FE, 12'h080, 5'h00, 3'h0, 16'h0000);
      finish(n);
      check("set one bit", 16'h0001, 16'(peer.out_bits[126]));
      peer.out_bits[255] = 1'b1;
      issue(bit_io_pkg::OP_SET_ZERO, 16'h007F, 12'h080, 5'h00, 3'h0, 16'h0000);
      finish(n);
      check("set zero bit", 16'h0000, 16'(peer.out_bits[255]));
      peer.in_bits[200] = 1'b1;
      issue(bit_io_pkg::OP_TEST, 16'h0000, 12'h0C8, 5'h00, 3'h0, 16'h0000);
      finish(n);
      check("test one", 16'hE00F, status_word);
      issue(bit_io_pkg::OP_TEST, 16'h0001, 12'h0C8, 5'h00, 3'h0, 16'h0000);
      finish(n);
      check("test zero", 16'hC00F, status_word);
   endtask : single_ops

   task automatic load_ops();
      int n, s0;
      logic [15:0] got;
      s0 = peer.nstrobe;
      issue(bit_io_pkg::OP_LOAD_MULTI, 16'h0000, 12'h190, 5'h10, 3'h0, 16'hA5C3);
      finish(n);
      for (int k = 0; k < 16; k++) got[k] = peer.out_bits[400 + k];
      check("load word", 16'hA5C3, got);
      check("load word strobes", 16'h0010, 16'(peer.nstrobe - s0));
      s0 = peer.nstrobe;
      issue(bit_io_pkg::OP_LOAD_MULTI, 16'h0000, 12'h1B8, 5'h05, 3'h0, 16'h16FF);
      finish(n);
      got = 16'h0000;
      for (int k = 0; k < 5; k++) got[k] = peer.out_bits[440 + k];
      check("load byte", 16'h0016, got);
      check("load byte strobes", 16'h0005, 16'(peer.nstrobe - s0));
      // odd byte is the low half of the operand word
      cmd_byte_odd = 1;
      issue(bit_io_pkg::OP_LOAD_MULTI, 16'h0000, 12'h1C0, 5'h03, 3'h0, 16'h16FD);
      finish(n);
      cmd_byte_odd = 0;
      got = 16'h0000;
      for (int k = 0; k < 3; k++) got[k] = peer.out_bits[448 + k];
      check("load odd byte", 16'h0005, got);
   endtask : load_ops

   task automatic store_ops();
      int n;
      for (int k = 0; k < 9; k++) peer.in_bits[300 + k] = k inside {0, 2, 5, 7, 8};
      issue(bit_io_pkg::OP_STORE_MULTI, 16'h0000, 12'h12C, 5'h09, 3'h0, 16'h0000);
      finish(n);
      check("store word", 16'h01A5, result);
      check("store word flag", 16'h0000, 16'(result_is_byte));
      peer.in_bits[321] = 1'b1;
      peer.in_bits[322] = 1'b1;
      issue(bit_io_pkg::OP_STORE_MULTI, 16'h0000, 12'h140, 5'h03, 3'h0, 16'h0000);
      finish(n);
      check("store byte", 16'h0006, result);
      check("store byte flag", 16'h0001, 16'(result_is_byte));
   endtask : store_ops

   task automatic external_ops();
      logic [2:0] codes [4] = '{bit_io_pkg::LOAD_RESTART_CODE, bit_io_pkg::CLOCK_OFF_CODE,
         bit_io_pkg::CLOCK_ON_CODE, bit_io_pkg::EXT_RESET_CODE};
      int n, s0;
      foreach (codes[i]) begin
         s0 = peer.nstrobe;
         issue(bit_io_pkg::OP_EXTERNAL, 16'h0000, 12'h000, 5'h00, codes[i], 16'h0000);
         finish(n);
         check("code strobes", 16'h0001, 16'(peer.nstrobe - s0));
         check("code value", 16'(codes[i]), 16'(peer.last_code));
      end
      s0 = peer.nstrobe;
      issue(bit_io_pkg::OP_EXTERNAL, 16'h0000, 12'h000, 5'h00, bit_io_pkg::IDLE_CODE, 16'h0000);
      repeat (20) @(negedge mclk);
      check("idle holds", 16'h0000, 16'(done));
      check("idle repeats", 16'h0001, 16'(peer.nstrobe - s0 >= 8));
      check("idle code", 16'(bit_io_pkg::IDLE_CODE), 16'(peer.last_code));
      intr_pending = 1;
      finish(n);
      @(negedge mclk);
      intr_pending = 0;
      check("memory during code", 16'h0000, 16'(code_mem));
   endtask : external_ops

   task automatic hold_op();
      int n;
      issue(bit_io_pkg::OP_SET_ONE, 16'h0105, 12'h080, 5'h00, 3'h0, 16'h0000);
      hold_request_n = 0;
      @(negedge mclk);
      @(negedge mclk);
      check("hold ack", 16'h0001, 16'(hold_acknowledge));
      check("floated", 16'h0000, 16'({addr_oe, data_oe, mem_ctrl_oe, io_strobe}));
      @(negedge mclk);
      hold_request_n = 1;
      finish(n);
      // represent, setup, strobe, then done
      check("hold extra cycle", 16'h0004, 16'(n));
      check("bit after hold", 16'h0001, 16'(peer.out_bits[133]));
   endtask : hold_op

   task automatic trap_op();
      logic [15:0] wa [3] = '{16'h020D, 16'h020E, 16'h020F};
      logic [15:0] wd [3] = '{16'h0300, 16'h1234, 16'hC00F};
      int w = 0;
      int r = 0;
      @(negedge mclk);
      load_request_n = 0;
      @(negedge mclk);
      load_request_n = 1;
      for (int i = 0; i < 60 && trap_done !== 1'b1; i++) begin
         if (memory_enable_n === 1'b0 && write_enable_n === 1'b0 && w < 3) begin
            check("trap write addr", wa[w], {1'b0, addr_bus});
            check("trap write data", wd[w], data_out);
            w++;
         end
         if (memory_enable_n === 1'b0 && data_bus_in_en === 1'b1) begin
            r++;
         end
         @(negedge mclk);
      end
      check("trap writes", 16'h0003, 16'(w));
      check("trap reads", 16'h0002, 16'(r));
      check("trap wp", 16'h0400, trap_wp);
      check("trap pc", 16'h5000, trap_pc);
      @(negedge mclk);
      check("trap status", 16'hC000, status_word);
   endtask : trap_op

   task automatic report_and_stop();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      #50000;
      failures++;
      $display("watchdog expired");
      report_and_stop();
   end

   initial begin
      repeat (12) @(posedge mclk);
      @(negedge mclk);
      rst = 0;
      single_ops();
      load_ops();
      store_ops();
      external_ops();
      hold_op();
      trap_op();
      report_and_stop();
   end
endmodule : bit_io_unit_tb
